// ---- hw/tas_supervisor.v ----
// Supervisor stage: replay count check, authorisation, tail removal and control commands.
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/100ps
`include "tas_consts.vh"
module tas_supervisor (
	input wire ref_clk, // Device clock.
	input wire srst, // Synchronous reset, active high.
	input wire seg_valid, // Segment octet offered.
	input wire [7:0] seg_data, // Segment octet, header first.
	input wire seg_last, // Last octet of the segment.
	output wire seg_ready, // Segment octet accepted.
	input wire sig_done, // Signature compare finished.
	input wire sig_match, // Signatures were equal.
	input wire [4:0] auth_map_ptr, // Highest authenticated access point pair.
	output wire key_use_prog, // Key in use: 1 programmable, 0 fixed.
	input wire [8:0] key_rd_addr, // Programmable key read address.
	output wire [7:0] key_rd_data, // Programmable key read data.
	output wire [8:0] fixed_addr, // Fixed key ROM address.
	input wire [7:0] fixed_data, // Fixed key ROM data.
	output wire psig_req, // Pseudo-signature request pulse.
	input wire psig_done, // Pseudo-signature ready pulse.
	input wire [39:0] psig_value, // Pseudo-signature.
	output wire fwd_valid, // Forwarded octet valid.
	output wire [7:0] fwd_data, // Forwarded octet.
	output wire fwd_last, // Last forwarded octet.
	input wire fwd_ready, // Segmentation layer takes the octet.
	output wire rep_valid, // Result report pulse.
	output wire rep_auth, // Segment authorised.
	output wire rep_fail, // Segment failed a check.
	output wire rep_noexec, // Command not executable.
	output wire [1:0] rep_seq_sel, // Sequence register named by segment.
	input wire [7:0] reg_addr, // Register byte address.
	input wire [31:0] reg_wdata, // Register write data.
	input wire reg_wr, // Register write strobe.
	input wire reg_rd, // Register read strobe.
	output wire [31:0] reg_rdata // Register read data.
);
	localparam [2:0] S_RX = 3'h0;
	localparam [2:0] S_SIG = 3'h1;
	localparam [2:0] S_FWD = 3'h2;
	localparam [2:0] S_COPY = 3'h3;
	localparam [2:0] S_PSIG = 3'h4;
	localparam [2:0] S_KWR = 3'h5;

	reg [2:0] state_q;
	reg [7:0] seg_mem [0:255];
	reg [7:0] key_mem [0:367];
	reg [7:0] ptr_q, len_q, hdr_q, cmd_q, rd_ptr_q;
	reg [63:0] arg_q;
	reg [71:0] tail_q;
	reg [29:0] pri_q, aux_q;
	reg [7:0] rec_q;
	reg key_q, key_use_q;
	reg [7:0] key_rd_q, fwd_data_q;
	reg fwd_valid_q, fwd_last_q;
	reg rep_valid_q, rep_auth_q, rep_fail_q, rep_noexec_q;
	reg [1:0] rep_sel_q;
	reg psig_req_q;
	reg [39:0] psig_q;
	reg [8:0] kw_addr_q, cnt_q, fixed_addr_q, cp_a_q;
	reg [2:0] kw_n_q;
	reg cp_v1_q, cp_v2_q;
	reg [31:0] rdata_q;

	// Decision terms from the captured tail and header.
	wire [31:0] seq_field_rx = tail_q[71:40];
	wire [1:0] sel = seq_field_rx[31:30];
	wire [29:0] cnt_rx = seq_field_rx[29:0];
	wire [5:0] map = hdr_q[5:0];
	wire is_cmd = (map == `TAS_MAP_CMD);
	wire [7:0] fwd_n = len_q - `TAS_TAIL_OCTETS;
	wire [7:0] blk_off = arg_q[63:56];
	reg [29:0] cur;
	reg fmt_ok;
	always @* begin
		case (sel)
			`TAS_SEQ_PRI: cur = pri_q;
			`TAS_SEQ_AUX: cur = aux_q;
			default: cur = {`TAS_REC_FILL, rec_q};
		endcase
	end
	wire cnt_ok = (sel != `TAS_SEQ_BAD) && (cnt_rx == cur) && (len_q >= `TAS_MIN_LEN);
	wire fwd_ok = !is_cmd && (map[4:0] <= auth_map_ptr);
	// Commands only execute after both checks; the sender always authenticates them.
	wire authd = sig_match && cnt_ok && (is_cmd || fwd_ok);
	always @* begin
		fmt_ok = 1'b0;
		if (hdr_q == `TAS_HDR_CMD) begin
			case (cmd_q)
				`TAS_CMD_NOP, `TAS_CMD_SEL_FIX, `TAS_CMD_SEL_PRG, `TAS_CMD_COPY: fmt_ok = (len_q == `TAS_LEN_G1);
				`TAS_CMD_SET: fmt_ok = (len_q == `TAS_LEN_G2) && (arg_q[63:62] != `TAS_SEQ_BAD);
				`TAS_CMD_BLK_A: fmt_ok = (len_q == `TAS_LEN_G3);
				`TAS_CMD_BLK_B: fmt_ok = (len_q == `TAS_LEN_G3) && (blk_off <= `TAS_BLK_B_MAX);
				default: fmt_ok = 1'b0;
			endcase
		end
	end
	wire exec = authd && is_cmd && fmt_ok;
	wire decide = (state_q == S_SIG) && sig_done;
	wire is_sel = (cmd_q == `TAS_CMD_SEL_FIX) || (cmd_q == `TAS_CMD_SEL_PRG);

	assign seg_ready = (state_q == S_RX);

	// Segment capture: buffer, header, identifier, argument and the last nine octets.
	always @(posedge ref_clk) begin
		if (seg_valid && seg_ready) begin
			seg_mem[ptr_q] <= seg_data;
		end
	end

	always @(posedge ref_clk) begin
		if (srst) begin
			state_q <= S_RX;
			ptr_q <= 8'h00;
			len_q <= 8'h00;
			hdr_q <= 8'h00;
			cmd_q <= 8'h00;
			arg_q <= 64'h0000_0000_0000_0000;
			tail_q <= 72'h00_0000_0000_0000_0000;
			pri_q <= 30'h0000_0000;
			aux_q <= 30'h0000_0000;
			rec_q <= 8'h00;
			key_q <= 1'b0;
			key_use_q <= 1'b0;
			rd_ptr_q <= 8'h00;
			fwd_valid_q <= 1'b0;
			fwd_last_q <= 1'b0;
			fwd_data_q <= 8'h00;
			rep_valid_q <= 1'b0;
			rep_auth_q <= 1'b0;
			rep_fail_q <= 1'b0;
			rep_noexec_q <= 1'b0;
			rep_sel_q <= 2'h0;
			psig_req_q <= 1'b0;
			psig_q <= 40'h00_0000_0000;
			kw_addr_q <= 9'h000;
			kw_n_q <= 3'h0;
			cnt_q <= 9'h000;
			fixed_addr_q <= 9'h000;
			cp_a_q <= 9'h000;
			cp_v1_q <= 1'b0;
			cp_v2_q <= 1'b0;
		end else begin
			rep_valid_q <= 1'b0;
			psig_req_q <= 1'b0;
			case (state_q)
				S_RX: begin
					if (reg_wr && (reg_addr == `TAS_REG_CTRL) && reg_wdata[`TAS_CTRL_FIX] && (ptr_q == 8'h00)) begin
						key_q <= 1'b0;
						key_use_q <= 1'b0;
					end
					if (seg_valid) begin
						tail_q <= {tail_q[63:0], seg_data};
						if (ptr_q == 8'h00) begin
							hdr_q <= seg_data;
						end
						if (ptr_q == 8'h01) begin
							cmd_q <= seg_data;
							// The named key is used for this segment's own check.
							if (hdr_q == `TAS_HDR_CMD && seg_data == `TAS_CMD_SEL_FIX) begin
								key_use_q <= 1'b0;
							end
							if (hdr_q == `TAS_HDR_CMD && seg_data == `TAS_CMD_SEL_PRG) begin
								key_use_q <= 1'b1;
							end
						end
						if (ptr_q >= 8'h02 && ptr_q <= 8'h09) begin
							arg_q[8'd79 - {ptr_q[4:0], 3'b000} -: 8] <= seg_data;
						end
						if (ptr_q != 8'hFF) begin
							ptr_q <= ptr_q + 8'h01;
						end
						if (seg_last) begin
							len_q <= (ptr_q == 8'hFF) ? ptr_q : ptr_q + 8'h01;
							ptr_q <= 8'h00;
							state_q <= S_SIG;
						end
					end
				end
				S_SIG: begin
					if (sig_done) begin
						rep_valid_q <= 1'b1;
						rep_auth_q <= authd;
						rep_fail_q <= !authd;
						rep_noexec_q <= authd && is_cmd && !fmt_ok;
						rep_sel_q <= sel;
						if (authd) begin
							case (sel)
								`TAS_SEQ_PRI: pri_q <= pri_q + 30'h0000_0001;
								`TAS_SEQ_AUX: aux_q <= aux_q + 30'h0000_0001;
								default: rec_q <= rec_q + 8'h01;
							endcase
						end
						// A set-count on the same register overrides the increment.
						if (exec && cmd_q == `TAS_CMD_SET) begin
							case (arg_q[63:62])
								`TAS_SEQ_PRI: pri_q <= arg_q[61:32];
								`TAS_SEQ_AUX: aux_q <= arg_q[61:32];
								default: rec_q <= arg_q[39:32];
							endcase
						end
						if (exec && is_sel) begin
							key_q <= key_use_q;
						end else begin
							key_use_q <= key_q;
						end
						if (!authd) begin
							state_q <= S_RX;
						end else if (!is_cmd) begin
							rd_ptr_q <= 8'h00;
							state_q <= S_FWD;
						end else if (exec && cmd_q == `TAS_CMD_COPY) begin
							cnt_q <= 9'h000;
							state_q <= S_COPY;
						end else if (exec && (cmd_q == `TAS_CMD_BLK_A || cmd_q == `TAS_CMD_BLK_B)) begin
							psig_req_q <= 1'b1;
							kw_addr_q <= (cmd_q == `TAS_CMD_BLK_B) ? `TAS_BLK_B_BASE + {1'b0, blk_off} : {1'b0, blk_off};
							state_q <= S_PSIG;
						end else begin
							state_q <= S_RX;
						end
					end
				end
				S_FWD: begin
					if (!fwd_valid_q || fwd_ready) begin
						if (rd_ptr_q < fwd_n) begin
							fwd_data_q <= seg_mem[rd_ptr_q];
							fwd_valid_q <= 1'b1;
							fwd_last_q <= (rd_ptr_q == fwd_n - 8'h01);
							rd_ptr_q <= rd_ptr_q + 8'h01;
						end else begin
							fwd_valid_q <= 1'b0;
							fwd_last_q <= 1'b0;
							state_q <= S_RX;
						end
					end
				end
				S_COPY: begin
					// The ROM answers one cycle after the address, so writes trail by two.
					fixed_addr_q <= cnt_q;
					cp_v1_q <= (cnt_q < `TAS_KEY_OCTETS);
					cp_a_q <= fixed_addr_q;
					cp_v2_q <= cp_v1_q;
					if (cnt_q < `TAS_KEY_OCTETS) begin
						cnt_q <= cnt_q + 9'h001;
					end else if (!cp_v1_q && !cp_v2_q) begin
						state_q <= S_RX;
					end
				end
				S_PSIG: begin
					if (psig_done) begin
						psig_q <= psig_value;
						kw_n_q <= 3'h0;
						state_q <= S_KWR;
					end
				end
				S_KWR: begin
					psig_q <= {psig_q[31:0], 8'h00};
					kw_addr_q <= kw_addr_q + 9'h001;
					kw_n_q <= kw_n_q + 3'h1;
					if (kw_n_q == `TAS_PSIG_OCTETS - 3'h1) begin
						state_q <= S_RX;
					end
				end
				default: state_q <= S_RX;
			endcase
		end
	end

	// Single write port into the programmable key store.
	wire kw_we = (state_q == S_KWR) && (kw_addr_q < `TAS_KEY_OCTETS);
	always @(posedge ref_clk) begin
		if (kw_we) begin
			key_mem[kw_addr_q] <= psig_q[39:32];
		end else if (cp_v2_q) begin
			key_mem[cp_a_q] <= fixed_data;
		end
	end

	always @(posedge ref_clk) begin
		if (srst) begin
			key_rd_q <= 8'h00;
		end else if (key_rd_addr < `TAS_KEY_OCTETS) begin
			key_rd_q <= key_mem[key_rd_addr];
		end else begin
			key_rd_q <= 8'h00;
		end
	end

	// Register read port; unmapped addresses read as zero.
	always @(posedge ref_clk) begin
		if (srst) begin
			rdata_q <= 32'h0000_0000;
		end else if (reg_rd) begin
			case (reg_addr)
				`TAS_REG_STATUS: rdata_q <= {27'h000_0000, rep_noexec_q, rep_fail_q, rep_auth_q,
					state_q != S_RX, key_q};
				`TAS_REG_SEQ_PRI: rdata_q <= {`TAS_SEQ_PRI, pri_q};
				`TAS_REG_SEQ_AUX: rdata_q <= {`TAS_SEQ_AUX, aux_q};
				`TAS_REG_SEQ_REC: rdata_q <= {`TAS_SEQ_REC, `TAS_REC_FILL, rec_q};
				default: rdata_q <= 32'h0000_0000;
			endcase
		end else begin
			rdata_q <= 32'h0000_0000;
		end
	end

	assign key_use_prog = key_use_q;
	assign key_rd_data = key_rd_q;
	assign fixed_addr = fixed_addr_q;
	assign psig_req = psig_req_q;
	assign fwd_valid = fwd_valid_q;
	assign fwd_data = fwd_data_q;
	assign fwd_last = fwd_last_q;
	assign rep_valid = rep_valid_q;
	assign rep_auth = rep_auth_q;
	assign rep_fail = rep_fail_q;
	assign rep_noexec = rep_noexec_q;
	assign rep_seq_sel = rep_sel_q;
	assign reg_rdata = rdata_q;
endmodule // tas_supervisor

// ---- hw/tas_consts.vh ----
// Constants for the telecommand authentication supervisor.
`ifndef TAS_CONSTS_VH
`define TAS_CONSTS_VH
`define TAS_KEY_OCTETS 9'h170
`define TAS_TAIL_OCTETS 8'h09
`define TAS_MIN_LEN 8'h0A
`define TAS_LEN_G1 8'h0B
`define TAS_LEN_G2 8'h0F
`define TAS_LEN_G3 8'h13
`define TAS_HDR_CMD 8'hFF
`define TAS_MAP_CMD 6'h3F
`define TAS_CMD_NOP 8'h00
`define TAS_CMD_SEL_FIX 8'h05
`define TAS_CMD_SEL_PRG 8'h06
`define TAS_CMD_COPY 8'h07
`define TAS_CMD_SET 8'h09
`define TAS_CMD_BLK_A 8'h0A
`define TAS_CMD_BLK_B 8'h0B
`define TAS_SEQ_PRI 2'h0
`define TAS_SEQ_AUX 2'h1
`define TAS_SEQ_REC 2'h2
`define TAS_SEQ_BAD 2'h3
`define TAS_REC_FILL 22'h3F_FFFF
`define TAS_BLK_B_BASE 9'h100
`define TAS_BLK_B_MAX 8'h70
`define TAS_PSIG_OCTETS 3'h5
`define TAS_REG_STATUS 8'h00
`define TAS_REG_SEQ_PRI 8'h04
`define TAS_REG_SEQ_AUX 8'h08
`define TAS_REG_SEQ_REC 8'h0C
`define TAS_REG_CTRL 8'h10
`define TAS_ST_KEY 0
`define TAS_ST_BUSY 1
`define TAS_ST_AUTH 2
`define TAS_ST_FAIL 3
`define TAS_ST_NOEXEC 4
`define TAS_CTRL_FIX 0
`endif

// ---- tb/tas_supervisor_chk.sv ----
// Port checker for the authentication supervisor.
`timescale 1ns/100ps
module tas_supervisor_chk (
	input wire ref_clk, // Clock.
	input wire srst, // Reset.
	input wire seg_valid, // Octet offered.
	input wire [7:0] seg_data, // Octet.
	input wire seg_last, // Last octet.
	input wire seg_ready, // Octet taken.
	input wire key_use_prog, // Key in use.
	input wire psig_req, // Pseudo-signature start.
	input wire fwd_valid, // Forward valid.
	input wire [7:0] fwd_data, // Forward octet.
	input wire fwd_last, // Forward last.
	input wire fwd_ready, // Forward taken.
	input wire rep_valid, // Report pulse.
	input wire rep_auth, // Authorised.
	input wire rep_fail, // Failed.
	input wire rep_noexec, // Not executable.
	input wire reg_rd, // Read strobe.
	input wire [31:0] reg_rdata // Read data.
);
	wire take = seg_valid && seg_ready;
	reg in_seg_q = 1'b0;
	reg key_q = 1'b0;
	reg [7:0] hdr_q = 8'h00;
	// Header and key are latched at the first octet, so each report is judged against its own segment.
	always @(posedge ref_clk) begin
		if (srst) begin
			in_seg_q <= 1'b0;
		end else if (take) begin
			in_seg_q <= !seg_last;
			if (!in_seg_q) begin
				hdr_q <= seg_data;
				key_q <= key_use_prog;
			end
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);
	a_reset_state: assert property (disable iff (1'b0) srst
		|=> seg_ready && !fwd_valid && !key_use_prog && !rep_valid) else $error("outputs not at reset values");
	a_last_busy: assert property (take && seg_last |=> !seg_ready)
		else $error("segment accepted after last octet");
	a_rep_pulse: assert property (rep_valid |=> !rep_valid)
		else $error("report longer than one cycle");
	a_rep_kind: assert property (rep_valid |-> rep_auth != rep_fail)
		else $error("report neither authorised nor failed");
	a_fail_key: assert property (rep_valid && rep_fail |-> key_use_prog == key_q && !psig_req)
		else $error("failed segment changed the key");
	a_fwd_start: assert property ($rose(fwd_valid) |-> $past(rep_valid) && $past(rep_auth) && fwd_data == hdr_q)
		else $error("forward without authorisation");
	a_cmd_kept: assert property (fwd_valid |-> hdr_q[5:0] != 6'h3F)
		else $error("command segment forwarded");
	a_fwd_hold: assert property (fwd_valid && !fwd_ready |=> fwd_valid && $stable(fwd_data) && $stable(fwd_last))
		else $error("forward octet dropped");
	a_psig_auth: assert property (psig_req |-> rep_valid && rep_auth && hdr_q == 8'hFF ##1 !psig_req)
		else $error("pseudo-signature without authorised command");
	a_read_idle: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
		else $error("read data outside read cycle");
	c_forward: cover property (fwd_valid && fwd_ready && fwd_last);
	c_psig: cover property (psig_req);
	c_noexec: cover property (rep_valid && rep_noexec);
	c_fail: cover property (rep_valid && rep_fail);
endmodule // tas_supervisor_chk

// ---- tb/tas_partner.sv ----
// Far-side model: signature unit, fixed key ROM, pseudo-signature engine and segmentation layer.
`timescale 1ns/100ps
module tas_partner #(
	parameter [39:0] PSIG = 40'h0
) (
	input wire ref_clk, // Clock.
	input wire srst, // Reset.
	input wire take_last, // Last octet taken.
	input wire match_in, // Verdict to give.
	input wire [8:0] fixed_addr, // ROM address.
	input wire psig_req, // Pseudo-signature start.
	output reg sig_done = 1'b0, // Verdict pulse.
	output reg sig_match = 1'b0, // Verdict.
	output reg [7:0] fixed_data = 8'h00, // ROM data.
	output reg psig_done = 1'b0, // Pseudo-signature pulse.
	output reg [39:0] psig_value = 40'h0, // Pseudo-signature.
	output reg fwd_ready = 1'b0 // Layer ready.
);
	integer seed = 32'h5d0c_3e97;
	integer sig_wait_q = -1;
	integer psig_wait_q = -1;
	// Idle result lines toggle so a stale value is never taken for a fresh one.
	always @(posedge ref_clk) begin
		fixed_data <= fixed_addr[7:0] ^ 8'h5A;
		fwd_ready <= ($random(seed) & 3) != 0;
		sig_done <= sig_wait_q == 0;
		sig_match <= (sig_wait_q == 0) ? match_in : ~sig_match;
		psig_done <= psig_wait_q == 0;
		psig_value <= (psig_wait_q == 0) ? PSIG : ~psig_value;
		sig_wait_q <= take_last ? ($random(seed) & 3) : sig_wait_q - (sig_wait_q >= 0);
		psig_wait_q <= psig_req ? 2 : psig_wait_q - (psig_wait_q >= 0);
		if (srst) begin
			sig_wait_q <= -1;
			psig_wait_q <= -1;
			sig_done <= 1'b0;
			psig_done <= 1'b0;
		end
	end
endmodule // tas_partner

// ---- tb/tb_tas_supervisor.sv ----
// Self-checking testbench for the authentication supervisor.
`timescale 1ns/100ps
module tb_tas_supervisor;
	localparam [39:0] PSIG = 40'h3C5A_9617_E2;
	reg ref_clk = 1'b0, srst = 1'b1, seg_valid = 1'b0, seg_last = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	reg match_in = 1'b0, kr_go = 1'b0, rd_q = 1'b0, kr_q = 1'b0;
	reg [7:0] seg_data = 8'h00, reg_addr = 8'h00;
	reg [31:0] reg_wdata = 32'h0000_0000, v;
	reg [8:0] key_rd_addr = 9'h000;
	reg [4:0] auth_map_ptr = 5'h04;
	wire seg_ready, sig_done, sig_match, key_use_prog, psig_req, psig_done, fwd_valid, fwd_last, fwd_ready;
	wire rep_valid, rep_auth, rep_fail, rep_noexec;
	wire [7:0] key_rd_data, fixed_data, fwd_data;
	wire [8:0] fixed_addr;
	wire [39:0] psig_value;
	wire [1:0] rep_seq_sel;
	wire [31:0] reg_rdata;
	integer seed = 32'h88fed808, error_cnt = 0, check_count = 0, t;
	reg [29:0] cnt [0:2];
	reg [7:0] body [$];
	reg [31:0] rq [$], fq [$], gq [$];
	tas_supervisor uut (.ref_clk, .srst, .seg_valid, .seg_data, .seg_last, .seg_ready, .sig_done, .sig_match,
		.auth_map_ptr, .key_use_prog, .key_rd_addr, .key_rd_data, .fixed_addr, .fixed_data, .psig_req, .psig_done,
		.psig_value, .fwd_valid, .fwd_data, .fwd_last, .fwd_ready, .rep_valid, .rep_auth, .rep_fail, .rep_noexec,
		.rep_seq_sel, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
	tas_partner #(.PSIG(PSIG)) far (.ref_clk, .srst, .take_last(seg_valid && seg_ready && seg_last), .match_in,
		.fixed_addr, .psig_req, .sig_done, .sig_match, .fixed_data, .psig_done, .psig_value, .fwd_ready);
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	task check(input [31:0] got, input [31:0] exp, input [63:0] what);
		check_count = check_count + 1;
		if (got !== exp) begin
			error_cnt = error_cnt + 1;
			$display("unexpected at %0t: %0s got %h want %h", $time, what, got, exp);
		end
	endtask
	always @(posedge ref_clk) begin
		rd_q <= reg_rd;
		kr_q <= kr_go;
		if (rd_q || kr_q) check(rd_q ? reg_rdata : {24'h0, key_rd_data}, gq.pop_front(), "read");
		if (rep_valid === 1'b1) check({27'h0, rep_auth, rep_fail, rep_noexec, rep_seq_sel}, rq.pop_front(), "report");
		if (fwd_valid === 1'b1 && fwd_ready) check({23'h0, fwd_last, fwd_data}, fq.pop_front(), "forward");
	end
	task wr(input [7:0] a, input [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask
	task rd(input [7:0] a, input [31:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		gq.push_back(e);
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(posedge ref_clk);
	endtask
	task kr(input [8:0] a, input [7:0] e);
		key_rd_addr <= a;
		kr_go <= 1'b1;
		gq.push_back({24'h0, e});
		@(posedge ref_clk);
		kr_go <= 1'b0;
		@(posedge ref_clk);
	endtask
	task rdcnt;
		rd(8'h04, {2'h0, cnt[0]});
		rd(8'h08, {2'h1, cnt[1]});
		rd(8'h0C, {2'h2, 22'h3F_FFFF, cnt[2][7:0]});
	endtask
	// Sends one segment with its tail; ex is {authorised, failed, not executable}.
	task seg(input [7:0] hdr, input [1:0] sel, input ok, input cok, input [2:0] ex);
		reg [31:0] sf;
		reg [7:0] b [$];
		integer n;
		sf = {sel, sel == 2'h2 ? {22'h3F_FFFF, cnt[2][7:0]} : cnt[sel]};
		if (!cok) sf = sf ^ 32'h0000_0001;
		b = {hdr, body, sf[31:24], sf[23:16], sf[15:8], sf[7:0]};
		repeat (5) b.push_back(8'($random(seed)));
		rq.push_back({27'h0, ex, sel});
		if (ex[2] && hdr[5:0] != 6'h3F) for (n = 0; n < b.size() - 9; n++) fq.push_back({23'h0, n == b.size() - 10, b[n]});
		if (ex[2]) cnt[sel] = cnt[sel] + 30'h1;
		match_in <= ok;
		for (n = 0; n < b.size(); n++) begin
			seg_valid <= 1'b1;
			seg_data <= b[n];
			seg_last <= n == b.size() - 1;
			do @(posedge ref_clk); while (seg_ready !== 1'b1);
		end
		seg_valid <= 1'b0;
		for (n = 0; n < 40 && rep_valid !== 1'b1; n++) @(posedge ref_clk);
		for (n = 0; n < 900 && seg_ready !== 1'b1; n++) @(posedge ref_clk);
		$display("segment %h done at %0t", hdr, $time);
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		#100_000;
		error_cnt = error_cnt + 1;
		complete_run;
	end
	initial begin
		for (t = 0; t < 3; t++) cnt[t] = 30'h0;
		repeat (10) @(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk);
		rdcnt;
		rd(8'h14, 32'h0000_0000);
		body = {8'h11, 8'h22, 8'h33};
		seg(8'hC4, 2'h0, 1'b1, 1'b1, 3'b100);
		seg(8'hE4, 2'h2, 1'b1, 1'b1, 3'b100);
		seg(8'hC5, 2'h0, 1'b1, 1'b1, 3'b010);
		auth_map_ptr <= 5'h05;
		seg(8'hC5, 2'h0, 1'b1, 1'b1, 3'b100);
		seg(8'hC4, 2'h1, 1'b0, 1'b1, 3'b010);
		seg(8'hC4, 2'h0, 1'b1, 1'b0, 3'b010);
		rdcnt;
		body = {8'h00};
		seg(8'hFF, 2'h0, 1'b1, 1'b1, 3'b100);
		for (t = 0; t < 2; t++) begin
			body = {8'h06 - t[7:0]};
			seg(8'hFF, 2'h0, 1'b1, 1'b1, 3'b100);
			check({31'h0, key_use_prog}, {31'h0, t == 0}, "key");
		end
		body = {8'h06};
		seg(8'hFF, 2'h0, 1'b0, 1'b1, 3'b010);
		check({31'h0, key_use_prog}, 32'h0000_0000, "key");
		seg(8'hFF, 2'h0, 1'b1, 1'b1, 3'b100);
		wr(8'h10, 32'h0000_0001);
		check({31'h0, key_use_prog}, 32'h0000_0000, "key");
		rd(8'h00, 32'h0000_0004);
		for (t = 0; t < 4; t++) begin
			v = {t[1:0], 30'($random(seed))};
			body = {8'h09, v[31:24], v[23:16], v[15:8], v[7:0]};
			seg(8'hFF, 2'h1, 1'b1, 1'b1, {2'b10, t == 3});
			if (t < 3) cnt[t] = v[29:0];
		end
		rdcnt;
		body = {8'h00, 8'h00};
		seg(8'hFF, 2'h0, 1'b1, 1'b1, 3'b101);
		body = {8'h03};
		seg(8'hFF, 2'h0, 1'b1, 1'b1, 3'b101);
		body = {8'h07};
		seg(8'hFF, 2'h0, 1'b1, 1'b1, 3'b100);
		kr(9'h16F, 8'h6F ^ 8'h5A);
		kr(9'h170, 8'h00);
		for (t = 0; t < 3; t++) begin
			body = {8'h0A + {7'h0, t != 0}, t == 2 ? 8'h71 : 8'h02};
			repeat (7) body.push_back(8'($random(seed)));
			seg(8'hFF, 2'h0, 1'b1, 1'b1, {2'b10, t == 2});
		end
		for (t = 0; t < 5; t++) begin
			kr(9'h002 + t[8:0], PSIG[39 - 8 * t -: 8]);
			kr(9'h102 + t[8:0], PSIG[39 - 8 * t -: 8]);
		end
		kr(9'h007, 8'h07 ^ 8'h5A);
		repeat (5) @(posedge ref_clk);
		complete_run;
	end
endmodule // tb_tas_supervisor
bind tas_supervisor tas_supervisor_chk chk (.ref_clk, .srst, .seg_valid, .seg_data, .seg_last, .seg_ready,
	.key_use_prog, .psig_req, .fwd_valid, .fwd_data, .fwd_last, .fwd_ready, .rep_valid, .rep_auth, .rep_fail,
	.rep_noexec, .reg_rd, .reg_rdata);
